// ==== logic/charge_cycle_supervisor.v ====
`include "charge_supervisor_consts.vh"
module charge_cycle_supervisor #(
    parameter AUTO_CHARGE = 1,
    parameter LONG_SEC = `LONG_TIMER_SEC,
    parameter SHORT_SEC = `SHORT_TIMER_SEC,
    parameter SEC_CYCLES = `SEC_TICK_CYC,
    parameter PULSE_CYCLES = `FAULT_PULSE_CYC
) (
    // Clock and synchronous active-low reset; reset is supply power-on.
    input wire I_CORE_CLK,
    input wire I_RST_B,
    // Analog comparator results and pin inputs, asynchronous.
    input wire I_BAT_BELOW_SHORT,
    input wire I_BAT_BELOW_WEAK,
    input wire I_BAT_BELOW_RECHARGE,
    input wire I_BAT_AT_REG,
    input wire I_CURRENT_AT_TERM,
    input wire I_OTG_PIN,
    input wire I_INPUT_FAULT,
    // Host register port, same clock domain; write strobe with values.
    input wire I_HOST_WRITE,
    input wire I_HOST_STATUS_READ,
    input wire I_CHARGE_DISABLE,
    input wire I_PARAM_RESET,
    input wire I_TIMER_KICK,
    input wire I_TERM_ENABLE,
    input wire [`VREG_WIDTH-1:0] I_REG_VOLTAGE,
    input wire [1:0] I_INPUT_LIMIT,
    input wire [`ICHG_WIDTH-1:0] I_FAST_CURRENT,
    input wire I_STAT_ENABLE,
    // Settings applied to the analog loops.
    output reg [`VREG_WIDTH-1:0] O_REG_VOLTAGE,
    output reg [1:0] O_INPUT_LIMIT,
    output reg [`ICHG_WIDTH-1:0] O_FAST_CURRENT,
    output reg O_TERM_ENABLE,
    output reg O_CHARGE_DISABLE,
    output reg O_PARAM_RESET,
    output reg O_TIMER_KICK,
    // Charger control and status.
    output reg O_CHARGE_ON,
    output reg O_SHORT_CURRENT,
    output reg O_HIGH_Z,
    output reg [2:0] O_PHASE,
    output reg [2:0] O_FAULT_STATE,
    output reg O_SHORT_TIMER_MODE,
    // Open-drain status pin.
    output wire O_STAT,
    output wire O_STAT_OE
);
    // Synchroniser stages for asynchronous inputs.
    reg [6:0] sync1;
    reg [6:0] sync2;
    wire bat_short = sync2[0];
    wire bat_weak = sync2[1];
    wire bat_rch = sync2[2];
    wire bat_reg = sync2[3];
    wire cur_term = sync2[4];
    wire otg = sync2[5];
    wire in_fault = sync2[6];

    // Timer state.
    reg long_mode;
    reg [11:0] sec_count;
    reg boot_done;
    reg prev_disable;
    reg fault_latched;
    reg fault_pend;
    reg fault_event;
    wire tick;
    reg [2:0] next_phase;

    // Clamp a regulation code into the legal 3.5 V to 4.44 V span.
    function [`VREG_WIDTH-1:0] clamp_vreg;
        input [`VREG_WIDTH-1:0] code;
        begin
            if (code > `VREG_MAX) begin
                clamp_vreg = `VREG_MAX;
            end else begin
                clamp_vreg = code;
            end
        end
    endfunction

    // Two-stage synchroniser for comparator and pin inputs.
    // It keeps running through reset, so the boot rules see settled levels on release.
    always @(posedge I_CORE_CLK) begin
        sync1 <= {I_INPUT_FAULT, I_OTG_PIN, I_CURRENT_AT_TERM, I_BAT_AT_REG,
                  I_BAT_BELOW_RECHARGE, I_BAT_BELOW_WEAK, I_BAT_BELOW_SHORT};
        sync2 <= sync1;
    end

    sec_tick #(
        .CYCLES(SEC_CYCLES)
    ) u_tick (
        .i_clk(I_CORE_CLK),
        .i_rst_b(I_RST_B),
        .o_tick(tick)
    );

    // Events that start a new cycle.
    wire disable_toggle = I_HOST_WRITE && (I_CHARGE_DISABLE != prev_disable);
    wire reset_req = I_HOST_WRITE && I_PARAM_RESET;
    wire new_cycle = disable_toggle || reset_req;
    wire long_expire = long_mode && tick && (sec_count >= LONG_SEC - 1);
    wire short_expire = !long_mode && tick && (sec_count >= SHORT_SEC - 1);
    wire charging = (O_PHASE == `PH_SHORT) || (O_PHASE == `PH_FAST);

    // Settings registers; host writes, power-on boot and defaults restore.
    always @(posedge I_CORE_CLK) begin
        if (!I_RST_B) begin
            O_REG_VOLTAGE <= `VREG_DEFAULT;
            O_INPUT_LIMIT <= `ILIM_100MA;
            O_FAST_CURRENT <= `ICHG_DEFAULT;
            O_TERM_ENABLE <= 1'b0;
            O_CHARGE_DISABLE <= 1'b0;
            O_PARAM_RESET <= 1'b0;
            O_TIMER_KICK <= 1'b0;
            prev_disable <= 1'b0;
        end else if (!boot_done) begin
            // Weak battery without host control takes its limit from OTG.
            if (bat_weak && AUTO_CHARGE != 0) begin
                O_INPUT_LIMIT <= otg ? `ILIM_500MA : `ILIM_100MA;
            end
        end else if (short_expire || reset_req) begin
            O_REG_VOLTAGE <= `VREG_DEFAULT;
            O_INPUT_LIMIT <= `ILIM_100MA;
            O_FAST_CURRENT <= `ICHG_DEFAULT;
            O_TERM_ENABLE <= 1'b0;
            O_PARAM_RESET <= reset_req;
            O_TIMER_KICK <= I_HOST_WRITE && I_TIMER_KICK;
            if (reset_req) begin
                O_CHARGE_DISABLE <= I_CHARGE_DISABLE;
                prev_disable <= I_CHARGE_DISABLE;
            end
        end else if (I_HOST_WRITE) begin
            O_REG_VOLTAGE <= clamp_vreg(I_REG_VOLTAGE);
            O_INPUT_LIMIT <= I_INPUT_LIMIT;
            O_FAST_CURRENT <= I_FAST_CURRENT;
            O_TERM_ENABLE <= I_TERM_ENABLE;
            O_CHARGE_DISABLE <= I_CHARGE_DISABLE;
            prev_disable <= I_CHARGE_DISABLE;
            O_TIMER_KICK <= I_TIMER_KICK;
            O_PARAM_RESET <= 1'b0;
        end else begin
            // Self-clearing bits drop one cycle after they take effect.
            O_TIMER_KICK <= 1'b0;
            O_PARAM_RESET <= 1'b0;
        end
    end

    // Boot marker: one cycle after reset release the boot rules are applied.
    always @(posedge I_CORE_CLK) begin
        if (!I_RST_B) begin
            boot_done <= 1'b0;
        end else begin
            boot_done <= 1'b1;
        end
    end

    // Safety timers: long mode until a host write, then short mode until the short timer expires and long mode restarts.
    always @(posedge I_CORE_CLK) begin
        if (!I_RST_B) begin
            long_mode <= 1'b1;
            sec_count <= 12'h0;
        end else if (short_expire) begin
            long_mode <= 1'b1;
            sec_count <= 12'h0;
        end else if (I_HOST_WRITE && boot_done) begin
            long_mode <= 1'b0;
            if (long_mode || I_TIMER_KICK) begin
                sec_count <= 12'h0;
            end
        end else if (!charging) begin
            if (long_mode) begin
                sec_count <= 12'h0;
            end
        end else if (tick) begin
            sec_count <= sec_count + 12'h1;
        end
    end

    // Charge phase sequencing.
    always @* begin
        next_phase = O_PHASE;
        case (O_PHASE)
            `PH_IDLE: begin
                if (bat_weak && long_mode && AUTO_CHARGE == 0) begin
                    next_phase = `PH_HIZ;
                end else if (!O_CHARGE_DISABLE || (bat_weak && long_mode)) begin
                    next_phase = `PH_SHORT;
                end
            end
            `PH_SHORT: begin
                if (!bat_short) begin
                    next_phase = `PH_FAST;
                end
            end
            `PH_FAST: begin
                if (bat_short) begin
                    next_phase = `PH_SHORT;
                end else if (O_TERM_ENABLE && bat_reg && cur_term && !bat_rch) begin
                    next_phase = `PH_DONE;
                end
            end
            `PH_DONE: begin
                if (bat_rch) begin
                    next_phase = `PH_SHORT;
                end
            end
            `PH_HIZ: begin
                if (I_HOST_WRITE) begin
                    next_phase = `PH_IDLE;
                end
            end
            `PH_OFF: begin
                next_phase = `PH_OFF;
            end
            default: begin
                next_phase = `PH_IDLE;
            end
        endcase
        if (O_PHASE != `PH_OFF && O_PHASE != `PH_IDLE && O_PHASE != `PH_HIZ) begin
            if (O_CHARGE_DISABLE) begin
                next_phase = `PH_DONE;
            end
            if (new_cycle || short_expire) begin
                next_phase = `PH_IDLE;
            end
        end
        if (O_PHASE == `PH_DONE && new_cycle) begin
            next_phase = `PH_IDLE;
        end
        if (long_expire) begin
            next_phase = `PH_OFF;
        end
    end

    // Phase register and derived controls.
    always @(posedge I_CORE_CLK) begin
        if (!I_RST_B) begin
            O_PHASE <= `PH_IDLE;
            O_CHARGE_ON <= 1'b0;
            O_SHORT_CURRENT <= 1'b0;
            O_HIGH_Z <= 1'b0;
            O_SHORT_TIMER_MODE <= 1'b0;
        end else if (boot_done) begin
            O_PHASE <= next_phase;
            O_CHARGE_ON <= (next_phase == `PH_SHORT) || (next_phase == `PH_FAST);
            O_SHORT_CURRENT <= (next_phase == `PH_SHORT);
            O_HIGH_Z <= (next_phase == `PH_HIZ);
            O_SHORT_TIMER_MODE <= !long_mode;
        end
    end

    // Fault field: timer fault holds until power-on; others wait for a read.
    always @(posedge I_CORE_CLK) begin
        if (!I_RST_B) begin
            O_FAULT_STATE <= `FAULT_NONE;
            fault_latched <= 1'b0;
            fault_pend <= 1'b0;
            fault_event <= 1'b0;
        end else begin
            fault_event <= long_expire || (in_fault && !fault_pend && charging);
            if (long_expire) begin
                fault_latched <= 1'b1;
            end
            if (long_expire || (in_fault && charging)) begin
                fault_pend <= 1'b1;
                if (!fault_pend || long_expire) begin
                    O_FAULT_STATE <= long_expire ? `FAULT_TIMER : 3'h1;
                end
            end else if (I_HOST_STATUS_READ && !fault_latched) begin
                fault_pend <= 1'b0;
                O_FAULT_STATE <= `FAULT_NONE;
            end
        end
    end

    fault_pulse #(
        .CYCLES(PULSE_CYCLES)
    ) u_pulse (
        .i_clk(I_CORE_CLK),
        .i_rst_b(I_RST_B),
        .i_fault(fault_event),
        .i_charging_low(charging && I_STAT_ENABLE),
        .o_pin(O_STAT),
        .o_pin_oe(O_STAT_OE)
    );
endmodule

// ==== logic/charge_supervisor_consts.vh ====
`ifndef CHARGE_SUPERVISOR_CONSTS_VH
`define CHARGE_SUPERVISOR_CONSTS_VH
// Core clock rate in hertz.
`define CLK_HZ 20000000
// Long safety timer length in seconds.
`define LONG_TIMER_SEC 1920
// Short safety timer length in seconds.
`define SHORT_TIMER_SEC 32
// Fault pulse length in microseconds.
`define FAULT_PULSE_US 128
// Fault pulse length in core clock cycles.
`define FAULT_PULSE_CYC ((`FAULT_PULSE_US * (`CLK_HZ / 1000000)))
// Cycles per second-tick.
`define SEC_TICK_CYC `CLK_HZ
// Regulation voltage code: 3.5 V plus 20 mV per step, six bits.
`define VREG_WIDTH 6
// Default regulation code, 3.54 V.
`define VREG_DEFAULT 6'h02
// Highest legal regulation code, 4.44 V.
`define VREG_MAX 6'h2f
// Input current limit codes.
`define ILIM_100MA 2'h0
`define ILIM_500MA 2'h1
`define ILIM_NONE 2'h3
// Fast charge current code width and default.
`define ICHG_WIDTH 4
`define ICHG_DEFAULT 4'h0
// Fault codes reported in the fault state field.
`define FAULT_NONE 3'h0
`define FAULT_TIMER 3'h6
// Charge phase codes.
`define PH_IDLE 3'h0
`define PH_SHORT 3'h1
`define PH_FAST 3'h2
`define PH_DONE 3'h3
`define PH_OFF 3'h4
`define PH_HIZ 3'h5
`endif

// ==== logic/sec_tick.v ====
`include "charge_supervisor_consts.vh"
// Divides the core clock down to a one-cycle pulse once per second.
module sec_tick #(
    parameter CYCLES = `SEC_TICK_CYC
) (
    // Clock and reset.
    input wire i_clk,
    input wire i_rst_b,
    // Tick output.
    output reg o_tick
);
    reg [31:0] count;

    // Count up and pulse when the count wraps.
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            count <= 32'h0;
            o_tick <= 1'b0;
        end else if (count >= CYCLES - 1) begin
            count <= 32'h0;
            o_tick <= 1'b1;
        end else begin
            count <= count + 32'h1;
            o_tick <= 1'b0;
        end
    end
endmodule

// ==== logic/fault_pulse.v ====
`include "charge_supervisor_consts.vh"
// Drives a low pulse on an open-drain status pin for a fixed number of cycles.
module fault_pulse #(
    parameter CYCLES = `FAULT_PULSE_CYC
) (
    // Clock and reset.
    input wire i_clk,
    input wire i_rst_b,
    // Fault event and charging indication.
    input wire i_fault,
    input wire i_charging_low,
    // Open-drain pin drive: output level and enable.
    output wire o_pin,
    output wire o_pin_oe
);
    reg [15:0] count;

    // Load the count on a fault and run it down to zero.
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            count <= 16'h0;
        end else if (i_fault) begin
            count <= CYCLES[15:0];
        end else if (count != 16'h0) begin
            count <= count - 16'h1;
        end
    end

    // The pin is only ever pulled low; released otherwise.
    assign o_pin = 1'b0;
    assign o_pin_oe = (count != 16'h0) || i_charging_low;
endmodule

// ==== test/charge_supervisor_chk.sv ====
`include "charge_supervisor_consts.vh"
// Checks the timing relations between host writes and the supervisor's outputs.
module charge_supervisor_chk (
    // Clock and reset.
    input wire logic I_CORE_CLK,
    input wire logic I_RST_B,
    // Host side.
    input wire logic I_HOST_WRITE,
    input wire logic I_PARAM_RESET,
    input wire logic I_TIMER_KICK,
    input wire logic I_CHARGE_DISABLE,
    input wire logic [5:0] I_REG_VOLTAGE,
    input wire logic [1:0] I_INPUT_LIMIT,
    // Applied settings and status.
    input wire logic [5:0] O_REG_VOLTAGE,
    input wire logic [1:0] O_INPUT_LIMIT,
    input wire logic O_TERM_ENABLE,
    input wire logic O_CHARGE_DISABLE,
    input wire logic O_PARAM_RESET,
    input wire logic O_TIMER_KICK,
    input wire logic O_CHARGE_ON,
    input wire logic [2:0] O_PHASE,
    input wire logic [2:0] O_FAULT_STATE,
    input wire logic O_SHORT_TIMER_MODE,
    input wire logic O_STAT,
    input wire logic O_STAT_OE
);
    timeunit 1ns;
    timeprecision 1ns;
    // Plain writes exclude parameter resets, which restore defaults instead.
    wire logic wr = I_HOST_WRITE && !I_PARAM_RESET;
    wire logic tfault = O_FAULT_STATE == `FAULT_TIMER;
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_RST_B);
    AST_VREG_APPLY: assert property (wr && I_REG_VOLTAGE <= `VREG_MAX |=>
        O_REG_VOLTAGE == $past(I_REG_VOLTAGE)) else $error("voltage not applied");
    AST_VREG_CLAMP: assert property (wr && I_REG_VOLTAGE > `VREG_MAX |=>
        O_REG_VOLTAGE == `VREG_MAX) else $error("voltage not clamped");
    AST_SET_APPLY: assert property (wr |=> O_INPUT_LIMIT == $past(I_INPUT_LIMIT) &&
        O_CHARGE_DISABLE == $past(I_CHARGE_DISABLE)) else $error("setting not applied");
    AST_KICK_PULSE: assert property (O_TIMER_KICK == $past(I_HOST_WRITE && I_TIMER_KICK))
        else $error("kick bit wrong");
    AST_PRESET_DEF: assert property (I_HOST_WRITE && I_PARAM_RESET |-> ##[1:3]
        (O_REG_VOLTAGE == `VREG_DEFAULT && !O_TERM_ENABLE)) else $error("no default");
    AST_PRESET_PULSE: assert property (O_PARAM_RESET == $past(I_HOST_WRITE && I_PARAM_RESET))
        else $error("reset bit wrong");
    AST_TERM_GATE: assert property (O_PHASE == `PH_DONE && $past(O_PHASE) != `PH_DONE |->
        $past(O_TERM_ENABLE) || $past(O_TERM_ENABLE, 2)) else $error("done without term");
    AST_FAULT_HOLD: assert property (tfault |=> tfault) else $error("timer fault cleared");
    AST_FAULT_OFF: assert property (tfault && $past(tfault) |-> !O_CHARGE_ON &&
        O_PHASE == `PH_OFF) else $error("charger on in fault");
    AST_FAULT_PULSE: assert property ($rose(tfault) |-> ##[0:4] O_STAT_OE)
        else $error("no fault pulse");
    AST_STAT_LOW: assert property (O_STAT_OE |-> !O_STAT) else $error("pin driven high");
    AST_SHORT_MODE: assert property (wr && !tfault |-> ##2 O_SHORT_TIMER_MODE)
        else $error("short timer not started");
    // Main scenarios reached.
    cover property (tfault);
    cover property (O_PHASE == `PH_DONE);
    cover property (O_PARAM_RESET);
endmodule

// ==== test/host_model.sv ====
// Host side of the control interface: issues one-cycle writes and status reads.
module host_model (
    // Clock.
    input wire logic i_clk,
    // Write strobe and values.
    output logic o_write = 1'b0,
    output logic o_read = 1'b0,
    output logic o_ce = 1'b0,
    output logic o_prst = 1'b0,
    output logic o_kick = 1'b0,
    output logic o_term = 1'b0,
    output logic [5:0] o_vreg = 6'h0,
    output logic [1:0] o_lim = 2'h0,
    output logic [3:0] o_cur = 4'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    // One write, launched and released on falling edges; the voltage and current values are inverted after.
    task automatic host_write(input logic [5:0] v, input logic [1:0] l, input logic [3:0] c,
        input logic ce, input logic t, input logic k, input logic p);
        @(negedge i_clk);
        o_vreg = v;
        o_lim = l;
        o_cur = c;
        o_ce = ce;
        o_term = t;
        o_kick = k;
        o_prst = p;
        o_write = 1'b1;
        @(negedge i_clk);
        o_write = 1'b0;
        o_kick = 1'b0;
        o_prst = 1'b0;
        o_vreg = ~v;
        o_cur = ~c;
    endtask
    // A status read pulse.
    task automatic status_read();
        @(negedge i_clk);
        o_read = 1'b1;
        @(negedge i_clk);
        o_read = 1'b0;
    endtask
endmodule

// ==== test/tb.sv ====
`include "charge_supervisor_consts.vh"
`define CHECK(what, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("mismatch %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic bs = 1'b0, bw = 1'b0, brc = 1'b0, ar = 1'b0, at = 1'b0, otg = 1'b0;
    logic inf = 1'b0, sen = 1'b0;
    wire w, rd, ce, pr, kk, te, cdis, chg_on, scur, hz, stm, stat, oe;
    wire [5:0] vr, vreg;
    wire [1:0] li, ilim;
    wire [3:0] cu, ichg;
    wire [2:0] phase, fault;
    int bad_count = 0, total_checks = 0, cycles = 0, seed;
    logic [5:0] v;
    logic [3:0] c;
    logic [1:0] lims [3] = '{`ILIM_100MA, `ILIM_500MA, `ILIM_NONE};
    logic e;
    // Core clock, 50 ns period.
    always #25 clk = ~clk;
    host_model host_model_inst (.i_clk(clk), .o_write(w), .o_read(rd), .o_ce(ce), .o_prst(pr),
        .o_kick(kk), .o_term(te), .o_vreg(vr), .o_lim(li), .o_cur(cu));
    charge_cycle_supervisor #(.AUTO_CHARGE(1), .LONG_SEC(8), .SHORT_SEC(4), .SEC_CYCLES(20),
        .PULSE_CYCLES(16)) charge_cycle_supervisor_inst (.I_CORE_CLK(clk), .I_RST_B(rst_b),
        .I_BAT_BELOW_SHORT(bs), .I_BAT_BELOW_WEAK(bw), .I_BAT_BELOW_RECHARGE(brc),
        .I_BAT_AT_REG(ar), .I_CURRENT_AT_TERM(at), .I_OTG_PIN(otg), .I_INPUT_FAULT(inf),
        .I_HOST_WRITE(w), .I_HOST_STATUS_READ(rd), .I_CHARGE_DISABLE(ce), .I_PARAM_RESET(pr),
        .I_TIMER_KICK(kk), .I_TERM_ENABLE(te), .I_REG_VOLTAGE(vr), .I_INPUT_LIMIT(li),
        .I_FAST_CURRENT(cu), .I_STAT_ENABLE(sen), .O_REG_VOLTAGE(vreg), .O_INPUT_LIMIT(ilim),
        .O_FAST_CURRENT(ichg), .O_TERM_ENABLE(), .O_CHARGE_DISABLE(cdis), .O_PARAM_RESET(),
        .O_TIMER_KICK(), .O_CHARGE_ON(chg_on), .O_SHORT_CURRENT(scur), .O_HIGH_Z(hz),
        .O_PHASE(phase), .O_FAULT_STATE(fault), .O_SHORT_TIMER_MODE(stm), .O_STAT(stat),
        .O_STAT_OE(oe));
    // Expected applied voltage code after clamping.
    function automatic logic [5:0] exp_vreg(input logic [5:0] x);
        return (x > `VREG_MAX) ? `VREG_MAX : x;
    endfunction
    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            finish_test();
        end
    end
    // Main sequence.
    initial begin
        seed = $urandom(44054);
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        `CHECK("vreg default", `VREG_DEFAULT, vreg);
        `CHECK("limit default", `ILIM_100MA, ilim);
        // Status pin pulled low while charging, then an input fault and its read-out.
        sen = 1'b1;
        repeat (2) @(negedge clk);
        `CHECK("stat low", 1'b1, oe);
        sen = 1'b0;
        inf = 1'b1;
        repeat (4) @(negedge clk);
        `CHECK("input fault", 3'h1, fault);
        `CHECK("fault pulse", 1'b1, oe);
        inf = 1'b0;
        repeat (3) @(negedge clk);
        `CHECK("fault held", 3'h1, fault);
        host_model_inst.status_read();
        @(negedge clk);
        `CHECK("fault read", `FAULT_NONE, fault);
        for (int n = 0; n < 9; n++) begin
            v = (n == 0) ? 6'h2f : (n == 1) ? 6'h30 : 6'($urandom);
            c = 4'($urandom);
            e = 1'($urandom);
            host_model_inst.host_write(v, lims[n % 3], c, e, 1'b0, 1'b1, 1'b0);
            `CHECK("vreg", exp_vreg(v), vreg);
            `CHECK("limit", lims[n % 3], ilim);
            `CHECK("current", c, ichg);
            `CHECK("disable", e, cdis);
            @(negedge clk);
            `CHECK("short mode", 1'b1, stm);
        end
        host_model_inst.host_write(6'h10, `ILIM_500MA, 4'h3, 1'b0, 1'b0, 1'b1, 1'b0);
        ar = 1'b1;
        at = 1'b1;
        repeat (10) @(negedge clk);
        `CHECK("no term", 1'b0, phase == `PH_DONE);
        host_model_inst.host_write(6'h10, `ILIM_500MA, 4'h3, 1'b0, 1'b1, 1'b1, 1'b0);
        repeat (10) @(negedge clk);
        `CHECK("done", `PH_DONE, phase);
        {ar, at, brc} = 3'b001;
        repeat (10) @(negedge clk);
        `CHECK("recharge", 1'b0, phase == `PH_DONE);
        bs = 1'b1;
        repeat (10) @(negedge clk);
        `CHECK("short current", 1'b1, scur);
        {bs, brc} = 2'b00;
        host_model_inst.host_write(6'h28, `ILIM_500MA, 4'h5, 1'b0, 1'b1, 1'b1, 1'b1);
        repeat (3) @(negedge clk);
        `CHECK("reset vreg", `VREG_DEFAULT, vreg);
        host_model_inst.host_write(6'h28, `ILIM_500MA, 4'h5, 1'b0, 1'b0, 1'b0, 1'b0);
        repeat (110) @(negedge clk);
        `CHECK("long mode", 1'b0, stm);
        `CHECK("restored", `VREG_DEFAULT, vreg);
        `CHECK("resumed", 1'b1, chg_on);
        repeat (200) @(negedge clk);
        `CHECK("fault", `FAULT_TIMER, fault);
        `CHECK("off", `PH_OFF, phase);
        `CHECK("released", 1'b0, oe);
        host_model_inst.status_read();
        host_model_inst.host_write(6'h10, `ILIM_100MA, 4'h1, 1'b0, 1'b0, 1'b1, 1'b0);
        repeat (5) @(negedge clk);
        `CHECK("fault kept", `FAULT_TIMER, fault);
        rst_b = 1'b0;
        bw = 1'b1;
        otg = 1'b1;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        repeat (6) @(negedge clk);
        `CHECK("fault cleared", `FAULT_NONE, fault);
        `CHECK("boot limit", `ILIM_500MA, ilim);
        `CHECK("boot charge", 1'b1, chg_on);
        `CHECK("no high z", 1'b0, hz);
        finish_test();
    end
endmodule
bind charge_cycle_supervisor charge_supervisor_chk charge_supervisor_chk_inst (
    .I_CORE_CLK(I_CORE_CLK), .I_RST_B(I_RST_B), .I_HOST_WRITE(I_HOST_WRITE),
    .I_PARAM_RESET(I_PARAM_RESET), .I_TIMER_KICK(I_TIMER_KICK),
    .I_CHARGE_DISABLE(I_CHARGE_DISABLE), .I_REG_VOLTAGE(I_REG_VOLTAGE),
    .I_INPUT_LIMIT(I_INPUT_LIMIT), .O_REG_VOLTAGE(O_REG_VOLTAGE), .O_INPUT_LIMIT(O_INPUT_LIMIT),
    .O_TERM_ENABLE(O_TERM_ENABLE), .O_CHARGE_DISABLE(O_CHARGE_DISABLE),
    .O_PARAM_RESET(O_PARAM_RESET), .O_TIMER_KICK(O_TIMER_KICK), .O_CHARGE_ON(O_CHARGE_ON),
    .O_PHASE(O_PHASE), .O_FAULT_STATE(O_FAULT_STATE), .O_SHORT_TIMER_MODE(O_SHORT_TIMER_MODE),
    .O_STAT(O_STAT), .O_STAT_OE(O_STAT_OE));
